// ### logic/ilm_exec.sv
// indexed load and multiply-add execution unit
// Behaviour
// - decode unsigned byte indexed load, group 000000, function 1000100101, bit 10 zero
// - decode signed halfword indexed load, function 0101100101
// - decode word indexed load, function 0110100101
// - byte load fetches 8 bits, zero-extends into destination
// - halfword load fetches 16 bits, sign-extends into destination
// - halfword load with address bit 0 set raises address error, no access
// - word load with low two address bits nonzero raises address error
// - loads may raise reserved, disabled, refill, invalid, bus, address, watch
// - decode signed multiply-add, 00101010 in bits 13..6, 111100 in 5..0
// - decode unsigned multiply-add, 01101010 in bits 13..6
// - selector zero addresses the original top/bottom pair
// - multiply-add never raises arithmetic exceptions, sum wraps
// - multiply-add writes only the selected pair, never a destination register
// - accumulator reads stall while a multiply-add result is pending
// - multiply-add signals only module disabled
// - two-bit selector picks one of four pairs, zero to three
`timescale 1ns/1ps
module ilm_exec (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic module_enable,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] src_a_data,
  input wire logic [31:0] src_b_data,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  input wire logic [2:0] mem_fault,
  input wire logic acc_rd_req,
  input wire logic [1:0] acc_rd_sel,
  input wire logic acc_rd_top,
  output logic issue_ready,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic wb_valid,
  output logic [4:0] wb_reg,
  output logic [31:0] wb_data,
  output logic exc_valid,
  output logic [2:0] exc_code,
  output logic mac_busy,
  output logic acc_rd_valid,
  output logic [31:0] acc_rd_data
);
  import ilm_pkg::*;

  typedef enum logic [1:0] {st_idle, st_mem, st_mul, st_acc} ilm_state_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // operands widened by sign or zero, low 64 bits of the product kept
  function automatic logic [63:0] ilm_mul64(
    input logic [31:0] a,
    input logic [31:0] b,
    input logic sgn
  );
    logic [63:0] xa;
    logic [63:0] xb;
    xa = {{32{sgn & a[31]}}, a};
    xb = {{32{sgn & b[31]}}, b};
    ilm_mul64 = xa * xb;
  endfunction : ilm_mul64

  // right-justified memory data extended per load size
  function automatic logic [31:0] ilm_extend(
    input logic [1:0] size,
    input logic [31:0] d
  );
    logic [31:0] r;
    r = d;
    if (size == ILM_SIZE_BYTE) begin
      r = {24'h00_0000, d[7:0]};
    end else if (size == ILM_SIZE_HALF) begin
      r = {{16{d[15]}}, d[15:0]};
    end
    ilm_extend = r;
  endfunction : ilm_extend

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ilm_state_t state;
  ilm_state_t next_state;
  logic [31:0] acc_top [4];
  logic [31:0] acc_bot [4];
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic op_signed;
  logic [1:0] pair_sel;
  logic [63:0] prod;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire in_group = instr_word[31:ILM_POS_OP] == ILM_MAJOR_OP;
  wire [9:0] fn10 = instr_word[9:0];
  wire [7:0] fn8 = instr_word[13:ILM_POS_XFN];
  wire xf_ok = instr_word[5:0] == ILM_XF_GROUP;
  wire is_ld_b = in_group && fn10 == ILM_FN_LD_BYTE;
  wire is_ld_h = in_group && fn10 == ILM_FN_LD_HALF;
  wire is_ld_w = in_group && fn10 == ILM_FN_LD_WORD;
  wire is_mac_s = in_group && xf_ok && fn8 == ILM_FN_MAC_S;
  wire is_mac_u = in_group && xf_ok && fn8 == ILM_FN_MAC_U;
  wire is_load = is_ld_b | is_ld_h | is_ld_w;
  wire is_mac = is_mac_s | is_mac_u;
  // a load with the must-be-zero bit set is not a valid encoding
  wire bad_form = is_load & instr_word[ILM_POS_ZERO];
  wire [1:0] ld_size = is_ld_b ? ILM_SIZE_BYTE : (is_ld_h ? ILM_SIZE_HALF : ILM_SIZE_WORD);
  wire [4:0] dst_field = instr_word[15:ILM_POS_RD];
  wire [1:0] sel_field = instr_word[15:ILM_POS_SEL];

  // ----------------------------------------------------------------
  // issue and early checks
  // ----------------------------------------------------------------
  // index arrives on port a (bits 25..21), base on port b (bits 20..16)
  wire [31:0] eff_addr = src_a_data + src_b_data;
  wire misalign = (is_ld_h & eff_addr[0])
    | (is_ld_w & (eff_addr[1:0] != 2'h0));
  wire take = instr_valid & issue_ready & (is_load | is_mac);
  // module disabled outranks the encoding and alignment checks
  wire [2:0] issue_exc = !module_enable ? ILM_EXC_MOD_OFF
    : bad_form ? ILM_EXC_RESV
    : (is_load & misalign) ? ILM_EXC_ADDR_ERR
    : ILM_EXC_NONE;
  wire issue_fault = take & (issue_exc != ILM_EXC_NONE);
  wire start_load = take & is_load & !issue_fault;
  wire start_mac = take & is_mac & !issue_fault;
  wire mem_done = (state == st_mem) & mem_ready;
  wire mem_bad = mem_done & (mem_fault != ILM_EXC_NONE);

  // ----------------------------------------------------------------
  // accumulator interlock
  // ----------------------------------------------------------------
  // pending from the issue cycle until the pair is written, so a read
  // arriving alongside a multiply-add never sees the stale pair
  wire mac_pending = start_mac | (state == st_mul) | (state == st_acc);
  wire rd_grant = acc_rd_req & !mac_pending & !acc_rd_valid;
  wire [31:0] rd_word = acc_rd_top ? acc_top[acc_rd_sel] : acc_bot[acc_rd_sel];
  wire [63:0] acc_sum = {acc_top[pair_sel], acc_bot[pair_sel]} + prod;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one instruction in flight keeps the control simple at the cost
  // of no overlap between a load and a multiply-add
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (start_load) begin
          next_state = st_mem;
        end else if (start_mac) begin
          next_state = st_mul;
        end
      end
      st_mem: begin
        if (mem_ready) begin
          next_state = st_idle;
        end
      end
      st_mul: begin
        next_state = st_acc;
      end
      st_acc: begin
        next_state = st_idle;
      end
    endcase
  end

  // state register and issue gate
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      issue_ready <= 1'b0;
      mac_busy <= 1'b0;
    end else begin
      state <= next_state;
      issue_ready <= next_state == st_idle;
      mac_busy <= next_state == st_mul || next_state == st_acc;
    end
  end

  // ----------------------------------------------------------------
  // memory request
  // ----------------------------------------------------------------
  // misaligned or faulted loads never reach this point
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_addr <= ILM_WORD_RESET;
      mem_size <= ILM_SIZE_BYTE;
      wb_reg <= 5'h00;
    end else if (start_load) begin
      mem_req <= 1'b1;
      mem_addr <= eff_addr;
      mem_size <= ld_size;
      wb_reg <= dst_field;
    end else if (mem_done) begin
      mem_req <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // write-back and exceptions
  // ----------------------------------------------------------------
  // only loads ever write a general register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_valid <= 1'b0;
      wb_data <= ILM_WORD_RESET;
    end else begin
      wb_valid <= mem_done & !mem_bad;
      if (mem_done) begin
        wb_data <= ilm_extend(mem_size, mem_rdata);
      end
    end
  end

  // issue checks and memory faults share one pulse
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_valid <= 1'b0;
      exc_code <= ILM_EXC_NONE;
    end else begin
      exc_valid <= issue_fault | mem_bad;
      if (issue_fault) begin
        exc_code <= issue_exc;
      end else if (mem_bad) begin
        exc_code <= mem_fault;
      end
    end
  end

  // ----------------------------------------------------------------
  // multiply-add datapath
  // ----------------------------------------------------------------
  // multiplier register is port a, multiplicand port b
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_a <= ILM_WORD_RESET;
      op_b <= ILM_WORD_RESET;
      op_signed <= 1'b0;
      pair_sel <= 2'h0;
    end else if (start_mac) begin
      op_a <= src_a_data;
      op_b <= src_b_data;
      op_signed <= is_mac_s;
      pair_sel <= sel_field;
    end
  end

  // product registered apart from the add to keep each stage short
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prod <= {ILM_WORD_RESET, ILM_WORD_RESET};
    end else if (state == st_mul) begin
      prod <= ilm_mul64(op_a, op_b, op_signed);
    end
  end

  // only the selected pair changes, the carry out of bit 63 is dropped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        acc_top[i] <= ILM_ACC_RESET;
        acc_bot[i] <= ILM_ACC_RESET;
      end
    end else if (state == st_acc) begin
      acc_top[pair_sel] <= acc_sum[63:32];
      acc_bot[pair_sel] <= acc_sum[31:0];
    end
  end

  // ----------------------------------------------------------------
  // accumulator read port
  // ----------------------------------------------------------------
  // requester holds its request until valid; one answer per request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_rd_valid <= 1'b0;
      acc_rd_data <= ILM_WORD_RESET;
    end else begin
      acc_rd_valid <= rd_grant;
      if (rd_grant) begin
        acc_rd_data <= rd_word;
      end
    end
  end

endmodule : ilm_exec

// ### pkg/ilm_pkg.sv
// constants for the indexed load and multiply-add execution block
package ilm_pkg;

  // ----------------------------------------------------------------
  // instruction field encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] ILM_MAJOR_OP = 6'h00;
  localparam logic [9:0] ILM_FN_LD_BYTE = 10'h225;
  localparam logic [9:0] ILM_FN_LD_HALF = 10'h165;
  localparam logic [9:0] ILM_FN_LD_WORD = 10'h1a5;
  localparam logic [5:0] ILM_XF_GROUP = 6'h3c;
  localparam logic [7:0] ILM_FN_MAC_S = 8'h2a;
  localparam logic [7:0] ILM_FN_MAC_U = 8'h6a;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ILM_POS_OP = 26;
  localparam int ILM_POS_RA = 21;
  localparam int ILM_POS_RB = 16;
  localparam int ILM_POS_RD = 11;
  localparam int ILM_POS_ZERO = 10;
  localparam int ILM_POS_SEL = 14;
  localparam int ILM_POS_XFN = 6;

  // ----------------------------------------------------------------
  // load sizes presented to the memory side
  // ----------------------------------------------------------------
  localparam logic [1:0] ILM_SIZE_BYTE = 2'h0;
  localparam logic [1:0] ILM_SIZE_HALF = 2'h1;
  localparam logic [1:0] ILM_SIZE_WORD = 2'h2;

  // ----------------------------------------------------------------
  // exception codes, zero means none
  // ----------------------------------------------------------------
  localparam logic [2:0] ILM_EXC_NONE = 3'h0;
  localparam logic [2:0] ILM_EXC_RESV = 3'h1;
  localparam logic [2:0] ILM_EXC_MOD_OFF = 3'h2;
  localparam logic [2:0] ILM_EXC_TLB_REFILL = 3'h3;
  localparam logic [2:0] ILM_EXC_TLB_INVALID = 3'h4;
  localparam logic [2:0] ILM_EXC_BUS_ERR = 3'h5;
  localparam logic [2:0] ILM_EXC_ADDR_ERR = 3'h6;
  localparam logic [2:0] ILM_EXC_WATCH = 3'h7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ILM_ACC_RESET = 32'h0000_0000;
  localparam logic [31:0] ILM_WORD_RESET = 32'h0000_0000;

endpackage : ilm_pkg

// ### tb/ilm_exec_monitor.sv
// concurrent checks on the ports of the indexed load and multiply-add unit
`timescale 1ns/1ps
module ilm_exec_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic module_enable,
  input wire logic instr_valid,
  input wire logic issue_ready,
  input wire logic mem_req,
  input wire logic mem_ready,
  input wire logic wb_valid,
  input wire logic exc_valid,
  input wire logic mac_busy,
  input wire logic acc_rd_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] src_a_data,
  input wire logic [31:0] src_b_data,
  input wire logic [31:0] mem_rdata,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] wb_data,
  input wire logic [2:0] mem_fault,
  input wire logic [2:0] exc_code,
  input wire logic [1:0] mem_size
);
  import ilm_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  wire [9:0] fn = instr_word[9:0];
  wire [7:0] xf = instr_word[13:6];
  wire grp = instr_word[31:26] == ILM_MAJOR_OP;
  wire take = instr_valid && issue_ready;
  wire is_ld = grp && (fn == ILM_FN_LD_BYTE || fn == ILM_FN_LD_HALF || fn == ILM_FN_LD_WORD);
  wire is_mac = grp && fn[5:0] == ILM_XF_GROUP && (xf == ILM_FN_MAC_S || xf == ILM_FN_MAC_U);
  wire [31:0] ea = src_a_data + src_b_data;
  wire mis = (fn == ILM_FN_LD_HALF && ea[0]) || (fn == ILM_FN_LD_WORD && ea[1:0] != 2'h0);
  wire ld_go = take && module_enable && is_ld && !instr_word[10];
  wire [1:0] sz = fn == ILM_FN_LD_BYTE ? ILM_SIZE_BYTE :
    fn == ILM_FN_LD_HALF ? ILM_SIZE_HALF : ILM_SIZE_WORD;
  wire done = mem_req && mem_ready;
  // extension is judged from the size the unit itself put out
  wire [31:0] ext = mem_size == ILM_SIZE_BYTE ? {24'h0, mem_rdata[7:0]} :
    mem_size == ILM_SIZE_HALF ? {{16{mem_rdata[15]}}, mem_rdata[15:0]} : mem_rdata;
  property p_mac_busy; take && module_enable && is_mac
    |=> (mac_busy && !issue_ready) [*2] ##1 (issue_ready && !mac_busy); endproperty
  a_mac_busy: assert property (p_mac_busy) else $error("mac busy window wrong");
  property p_mac_quiet; take && module_enable && is_mac |=> (!wb_valid && !exc_valid) [*3];
  endproperty
  a_mac_quiet: assert property (p_mac_quiet) else $error("mac gave a response");
  property p_mod_off; take && !module_enable && (is_ld || is_mac)
    |=> exc_valid && exc_code == ILM_EXC_MOD_OFF && !mem_req; endproperty
  a_mod_off: assert property (p_mod_off) else $error("disabled code wrong");
  property p_resv; take && module_enable && is_ld && instr_word[10]
    |=> exc_valid && exc_code == ILM_EXC_RESV && !mem_req; endproperty
  a_resv: assert property (p_resv) else $error("reserved code wrong");
  property p_mis; ld_go && mis |=> exc_valid && exc_code == ILM_EXC_ADDR_ERR && !mem_req;
  endproperty
  a_mis: assert property (p_mis) else $error("alignment fault wrong");
  property p_ea; ld_go && !mis |=> mem_req && mem_addr == $past(ea) && mem_size == $past(sz);
  endproperty
  a_ea: assert property (p_ea) else $error("bad load request");
  property p_fault; done && mem_fault != ILM_EXC_NONE
    |=> exc_valid && !wb_valid && !mem_req && exc_code == $past(mem_fault); endproperty
  a_fault: assert property (p_fault) else $error("memory fault lost");
  property p_ext; done && mem_fault == ILM_EXC_NONE |=> wb_valid && wb_data == $past(ext);
  endproperty
  a_ext: assert property (p_ext) else $error("load data wrong");
  property p_rd_stall; mac_busy |=> !acc_rd_valid; endproperty
  a_rd_stall: assert property (p_rd_stall) else $error("read during mac");
endmodule : ilm_exec_monitor

// ### tb/ilm_mem_model.sv
// behavioural memory side answering the unit's load requests
`timescale 1ns/1ps
module ilm_mem_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] delay,
  input wire logic [2:0] fault,
  output logic mem_ready,
  output logic [31:0] mem_rdata,
  output logic [2:0] mem_fault
);
  logic [1:0] cnt;
  wire [31:0] word = mem_addr * 32'h9e37_79b1;
  // data and fault mean nothing outside the ready cycle, so show the inverse there
  assign mem_rdata = mem_ready ? word : ~word;
  assign mem_fault = mem_ready ? fault : ~fault;
  // one-cycle answer after delay plus one idle cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ready <= 1'b0;
      cnt <= 2'h0;
    end else if (mem_ready || !mem_req) begin
      mem_ready <= 1'b0;
      cnt <= 2'h0;
    end else if (cnt == delay) begin
      mem_ready <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule : ilm_mem_model

// ### tb/tb_ilm_exec.sv
// self-checking bench for the indexed load and multiply-add unit
`timescale 1ns/1ps
module tb_ilm_exec;
  import ilm_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic module_enable = 1'b1;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h0;
  logic [31:0] src_a_data = 32'h0;
  logic [31:0] src_b_data = 32'h0;
  logic acc_rd_req = 1'b0;
  logic [1:0] acc_rd_sel = 2'h0;
  logic acc_rd_top = 1'b0;
  logic [1:0] delay = 2'h0;
  logic [2:0] fault = 3'h0;
  logic mem_ready, mem_req, issue_ready, wb_valid, exc_valid, mac_busy, acc_rd_valid;
  logic [31:0] mem_rdata, mem_addr, wb_data, acc_rd_data;
  logic [2:0] mem_fault, exc_code;
  logic [1:0] mem_size;
  logic [4:0] wb_reg;
  logic [63:0] acc [4];
  logic [2:0] fc [7] = '{3'h0, 3'h0, 3'h0, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [9:0] fns [3] = '{ILM_FN_LD_BYTE, ILM_FN_LD_HALF, ILM_FN_LD_WORD};
  logic [31:0] seed = 32'he4d5af9b;
  int err_count = 0;
  int cmp_count = 0;
  always #12.5 core_clk = ~core_clk;
  ilm_exec i_dut (.core_clk(core_clk), .rst_n(rst_n), .module_enable(module_enable),
    .instr_valid(instr_valid), .instr_word(instr_word), .src_a_data(src_a_data),
    .src_b_data(src_b_data), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .mem_fault(mem_fault), .acc_rd_req(acc_rd_req), .acc_rd_sel(acc_rd_sel),
    .acc_rd_top(acc_rd_top), .issue_ready(issue_ready), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_size(mem_size), .wb_valid(wb_valid), .wb_reg(wb_reg),
    .wb_data(wb_data), .exc_valid(exc_valid), .exc_code(exc_code), .mac_busy(mac_busy),
    .acc_rd_valid(acc_rd_valid), .acc_rd_data(acc_rd_data));
  ilm_mem_model i_mem (.core_clk(core_clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .delay(delay), .fault(fault), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .mem_fault(mem_fault));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // expected destination value from the model's data pattern
  function automatic logic [31:0] ld_exp(logic [9:0] fn, logic [31:0] ea);
    logic [31:0] w;
    w = ea * 32'h9e37_79b1;
    if (fn == ILM_FN_LD_BYTE) return {24'h0, w[7:0]};
    if (fn == ILM_FN_LD_HALF) return {{16{w[15]}}, w[15:0]};
    return w;
  endfunction : ld_exp
  task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // offer one instruction; returns at the edge that takes it
  task automatic issue(logic [31:0] iw, logic [31:0] a, logic [31:0] b);
    @(negedge core_clk);
    for (int n = 0; n < 50 && issue_ready !== 1'b1; n++) @(negedge core_clk);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word <= iw;
    src_a_data <= a;
    src_b_data <= b;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    src_a_data <= rnd();
  endtask : issue
  task automatic ld(logic [9:0] fn, logic b10, logic [31:0] a, logic [31:0] b, logic en);
    logic [31:0] ea;
    logic [4:0] rd;
    logic [2:0] f, e;
    logic mis, pre;
    ea = a + b;
    rd = 5'(rnd());
    f = fc[rnd() % 7];
    mis = (fn == ILM_FN_LD_HALF && ea[0]) || (fn == ILM_FN_LD_WORD && ea[1:0] != 2'h0);
    pre = !en || b10 || mis;
    e = !en ? ILM_EXC_MOD_OFF : b10 ? ILM_EXC_RESV : mis ? ILM_EXC_ADDR_ERR : f;
    @(posedge core_clk);
    delay <= 2'(rnd());
    fault <= f;
    module_enable <= en;
    issue({ILM_MAJOR_OP, 5'(rnd()), 5'(rnd()), rd, b10, fn}, a, b);
    @(negedge core_clk);
    chk("mem_req", mem_req, !pre);
    if (!pre) chk("mem_addr", mem_addr, ea);
    for (int n = 0; n < 20 && wb_valid !== 1'b1 && exc_valid !== 1'b1; n++) @(negedge core_clk);
    chk("exc_valid", exc_valid, e != ILM_EXC_NONE);
    chk("wb_valid", wb_valid, e == ILM_EXC_NONE);
    if (e != ILM_EXC_NONE) chk("exc_code", exc_code, e);
    else chk("wb_data", wb_data, ld_exp(fn, ea));
    if (e == ILM_EXC_NONE) chk("wb_reg", wb_reg, rd);
  endtask : ld
  // hold the read request until it is answered, drop it at the edge that ends the answer cycle
  task automatic rd_acc(logic [1:0] s, logic top, logic [31:0] exp);
    @(posedge core_clk);
    acc_rd_req <= 1'b1;
    acc_rd_sel <= s;
    acc_rd_top <= top;
    @(negedge core_clk);
    for (int n = 0; n < 20 && acc_rd_valid !== 1'b1; n++) @(negedge core_clk);
    chk("acc_rd_valid", acc_rd_valid, 1'b1);
    chk("acc_rd_data", acc_rd_data, exp);
    @(posedge core_clk);
    acc_rd_req <= 1'b0;
  endtask : rd_acc
  task automatic mac(logic u, logic [1:0] s, logic [31:0] a, logic [31:0] b, logic en);
    logic [63:0] p;
    p = u ? {32'h0, a} * {32'h0, b} : {{32{a[31]}}, a} * {{32{b[31]}}, b};
    if (en) acc[s] = acc[s] + p;
    @(posedge core_clk);
    module_enable <= en;
    issue({ILM_MAJOR_OP, 5'(rnd()), 5'(rnd()), s, u ? ILM_FN_MAC_U : ILM_FN_MAC_S,
      ILM_XF_GROUP}, a, b);
    rd_acc(s, 1'b1, acc[s][63:32]);
    rd_acc(s, 1'b0, acc[s][31:0]);
  endtask : mac
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) acc[i] = 64'h0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    // corners: wrapping sum, misaligned word, bit 10 set, module off
    ld(ILM_FN_LD_HALF, 1'b0, 32'hffff_ffff, 32'h2, 1'b1);
    ld(ILM_FN_LD_WORD, 1'b0, 32'h1, 32'h1, 1'b1);
    ld(ILM_FN_LD_BYTE, 1'b1, 32'h10, 32'h0, 1'b1);
    ld(ILM_FN_LD_WORD, 1'b0, 32'h0, 32'h4, 1'b0);
    for (int i = 0; i < 60; i++) ld(fns[i % 3], 1'b0, rnd(), rnd(), 1'b1);
    $display("test loads done");
    // two largest unsigned products overflow pair three
    mac(1'b1, 2'h3, 32'hffff_ffff, 32'hffff_ffff, 1'b1);
    mac(1'b1, 2'h3, 32'hffff_ffff, 32'hffff_ffff, 1'b1);
    mac(1'b0, 2'h0, 32'h8000_0000, 32'h8000_0000, 1'b0);
    for (int i = 0; i < 30; i++) mac(1'(rnd()), 2'(rnd()), rnd(), rnd(), 1'b1);
    for (int i = 0; i < 8; i++) begin
      rd_acc(2'(i >> 1), i[0], i[0] ? acc[i >> 1][63:32] : acc[i >> 1][31:0]);
    end
    $display("test multiply-add done");
    stop_test();
  end
  // hang guard, far beyond the expected run
  initial begin
    #1_000_000;
    err_count++;
    stop_test();
  end
endmodule : tb_ilm_exec
bind ilm_exec ilm_exec_monitor i_mon (.core_clk(core_clk), .rst_n(rst_n),
  .module_enable(module_enable), .instr_valid(instr_valid), .issue_ready(issue_ready),
  .mem_req(mem_req), .mem_ready(mem_ready), .wb_valid(wb_valid), .exc_valid(exc_valid),
  .mac_busy(mac_busy), .acc_rd_valid(acc_rd_valid), .instr_word(instr_word),
  .src_a_data(src_a_data), .src_b_data(src_b_data), .mem_rdata(mem_rdata),
  .mem_addr(mem_addr), .wb_data(wb_data), .mem_fault(mem_fault), .exc_code(exc_code),
  .mem_size(mem_size));
